// [design/bpao_pkg.sv]
// Functional notes
// - Eight bidirectional pins, per-pin direction bits
// - Direction bit one makes pin input
// - Direction bit zero drives latch value
// - Latch register reads latch, not pins
// - Each pin configured independently
// - Reset leaves all pins as inputs
// - Enabled memory interface drives address pins
// - Address beats latch on those pins
// - Direction ignored there, register unchanged
// - Pins 0-3 carry address 16-19
// - Interface enabled when bus-disable bit clear
package bpao_pkg;
  // ****************************************
  // Widths
  // ****************************************
  localparam int unsigned PORT_W = 8;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned OVR_W = 4;
  localparam int unsigned DATA_W = 8;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [3:0] OFF_DIR = 4'h0;
  localparam logic [3:0] OFF_PIN = 4'h1;
  localparam logic [3:0] OFF_LAT = 4'h2;
  localparam logic [3:0] OFF_MIC = 4'h3;
  // ****************************************
  // Fields and reset values
  // ****************************************
  localparam int unsigned MIC_BUS_DIS_BIT = 7;
  localparam logic [7:0] DIR_RST = 8'hff;
  localparam logic [7:0] LAT_RST = 8'h00;
  localparam logic [7:0] MIC_RST = 8'h80;
  localparam logic [7:0] UNMAPPED_RD = 8'h00;
endpackage

// [design/bpao_pin_cell.sv]
`timescale 1ns/1ps
module bpao_pin_cell (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic dir_in,
  input wire logic lat_in,
  input wire logic ovr_en_in,
  input wire logic ovr_val_in,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_out,
  output logic pin_sync_out
);
  // ****************************************
  // Driver and input synchroniser
  // ****************************************
  logic out_reg, out_next, oe_reg, oe_next, s1_reg, s2_reg;
  always_comb begin
    if (ovr_en_in) begin
      out_next = ovr_val_in;
      oe_next = 1'b1;
    end else begin
      out_next = lat_in;
      oe_next = ~dir_in;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      out_reg <= 1'b0;
      oe_reg <= 1'b0;
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
    end else begin
      out_reg <= out_next;
      oe_reg <= oe_next;
      s1_reg <= pin_in;
      s2_reg <= s1_reg;
    end
  end
  assign pin_out = out_reg;
  assign pin_oe_out = oe_reg;
  assign pin_sync_out = s2_reg;
endmodule

// [design/bpao_top.sv]
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module bpao_top (
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  input wire logic [3:0] ext_addr_hi_in,
  input wire logic [7:0] port_pin_in,
  output logic [7:0] port_pin_out,
  output logic [7:0] port_pin_oe_out,
  output logic ext_bus_enabled_out
);
  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] dir_reg, dir_next, lat_reg, lat_next, mic_reg, mic_next;
  logic [7:0] rdata_reg, rdata_next;
  logic ebus_reg, ebus_next;
  logic [7:0] pin_sync;
  logic ovr_en;
  logic wr_dir, wr_pin, wr_lat, wr_mic;

  // ****************************************
  // Write decode
  // ****************************************
  assign wr_dir = wr_in && (addr_in == bpao_pkg::OFF_DIR);
  assign wr_pin = wr_in && (addr_in == bpao_pkg::OFF_PIN);
  assign wr_lat = wr_in && (addr_in == bpao_pkg::OFF_LAT);
  assign wr_mic = wr_in && (addr_in == bpao_pkg::OFF_MIC);

  // ****************************************
  // Direction register
  // ****************************************
  always_comb begin
    dir_next = dir_reg;
    if (wr_dir) begin
      dir_next = wdata_in;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      dir_reg <= bpao_pkg::DIR_RST;
    end else begin
      dir_reg <= dir_next;
    end
  end

  // ****************************************
  // Output latch
  // ****************************************
  // Both latch offsets write here; pins see it one cycle later
  always_comb begin
    lat_next = lat_reg;
    if (wr_lat) begin
      lat_next = wdata_in;
    end else if (wr_pin) begin
      lat_next = wdata_in;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      lat_reg <= bpao_pkg::LAT_RST;
    end else begin
      lat_reg <= lat_next;
    end
  end

  // ****************************************
  // Memory interface control
  // ****************************************
  always_comb begin
    mic_next = mic_reg;
    if (wr_mic) begin
      mic_next = wdata_in;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      mic_reg <= bpao_pkg::MIC_RST;
    end else begin
      mic_reg <= mic_next;
    end
  end

  // ****************************************
  // Override enable
  // ****************************************
  // Bus-disable set at reset keeps the address pins free for software
  assign ovr_en = ~mic_reg[bpao_pkg::MIC_BUS_DIS_BIT];
  always_comb begin
    ebus_next = ovr_en;
  end
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      ebus_reg <= 1'b0;
    end else begin
      ebus_reg <= ebus_next;
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always_comb begin
    rdata_next = 8'h00;
    if (rd_in) begin
      case (addr_in)
        bpao_pkg::OFF_DIR: rdata_next = dir_reg;
        bpao_pkg::OFF_PIN: rdata_next = pin_sync;
        bpao_pkg::OFF_LAT: rdata_next = lat_reg;
        bpao_pkg::OFF_MIC: rdata_next = mic_reg;
        default: rdata_next = bpao_pkg::UNMAPPED_RD;
      endcase
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (!reset_n_in) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end
  assign rdata_out = rdata_reg;
  assign ext_bus_enabled_out = ebus_reg;

  // ****************************************
  // Pin cells
  // ****************************************
  // Address pins need a flop too, so outputs stay registered
  // Pins 0-3 share the override; pins 4-7 never see it
  bpao_pin_cell pin_cell_0 (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .dir_in(dir_reg[0]),
    .lat_in(lat_reg[0]),
    .ovr_en_in(ovr_en),
    .ovr_val_in(ext_addr_hi_in[0]),
    .pin_in(port_pin_in[0]),
    .pin_out(port_pin_out[0]),
    .pin_oe_out(port_pin_oe_out[0]),
    .pin_sync_out(pin_sync[0])
  );
  bpao_pin_cell pin_cell_1 (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .dir_in(dir_reg[1]),
    .lat_in(lat_reg[1]),
    .ovr_en_in(ovr_en),
    .ovr_val_in(ext_addr_hi_in[1]),
    .pin_in(port_pin_in[1]),
    .pin_out(port_pin_out[1]),
    .pin_oe_out(port_pin_oe_out[1]),
    .pin_sync_out(pin_sync[1])
  );
  bpao_pin_cell pin_cell_2 (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .dir_in(dir_reg[2]),
    .lat_in(lat_reg[2]),
    .ovr_en_in(ovr_en),
    .ovr_val_in(ext_addr_hi_in[2]),
    .pin_in(port_pin_in[2]),
    .pin_out(port_pin_out[2]),
    .pin_oe_out(port_pin_oe_out[2]),
    .pin_sync_out(pin_sync[2])
  );
  bpao_pin_cell pin_cell_3 (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .dir_in(dir_reg[3]),
    .lat_in(lat_reg[3]),
    .ovr_en_in(ovr_en),
    .ovr_val_in(ext_addr_hi_in[3]),
    .pin_in(port_pin_in[3]),
    .pin_out(port_pin_out[3]),
    .pin_oe_out(port_pin_oe_out[3]),
    .pin_sync_out(pin_sync[3])
  );

  bpao_pin_cell pin_cell_4 (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .dir_in(dir_reg[4]),
    .lat_in(lat_reg[4]),
    .ovr_en_in(1'b0),
    .ovr_val_in(1'b0),
    .pin_in(port_pin_in[4]),
    .pin_out(port_pin_out[4]),
    .pin_oe_out(port_pin_oe_out[4]),
    .pin_sync_out(pin_sync[4])
  );
  bpao_pin_cell pin_cell_5 (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .dir_in(dir_reg[5]),
    .lat_in(lat_reg[5]),
    .ovr_en_in(1'b0),
    .ovr_val_in(1'b0),
    .pin_in(port_pin_in[5]),
    .pin_out(port_pin_out[5]),
    .pin_oe_out(port_pin_oe_out[5]),
    .pin_sync_out(pin_sync[5])
  );
  bpao_pin_cell pin_cell_6 (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .dir_in(dir_reg[6]),
    .lat_in(lat_reg[6]),
    .ovr_en_in(1'b0),
    .ovr_val_in(1'b0),
    .pin_in(port_pin_in[6]),
    .pin_out(port_pin_out[6]),
    .pin_oe_out(port_pin_oe_out[6]),
    .pin_sync_out(pin_sync[6])
  );
  bpao_pin_cell pin_cell_7 (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .dir_in(dir_reg[7]),
    .lat_in(lat_reg[7]),
    .ovr_en_in(1'b0),
    .ovr_val_in(1'b0),
    .pin_in(port_pin_in[7]),
    .pin_out(port_pin_out[7]),
    .pin_oe_out(port_pin_oe_out[7]),
    .pin_sync_out(pin_sync[7])
  );

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  chk_input_hiz: assert property (!ovr_en && dir_reg[5] |=> !port_pin_oe_out[5])
    else $error("input pin driven");
  chk_output_latch: assert property (!ovr_en && !dir_reg[6] |=>
    port_pin_oe_out[6] && port_pin_out[6] == $past(lat_reg[6]))
    else $error("output pin not latch");
  chk_lat_write: assert property (wr_in && addr_in == bpao_pkg::OFF_LAT |=>
    lat_reg == $past(wdata_in))
    else $error("latch write lost");
  chk_pin_write: assert property (wr_in && addr_in == bpao_pkg::OFF_PIN |=>
    lat_reg == $past(wdata_in))
    else $error("pin write not latched");
  chk_pin_read: assert property (rd_in && addr_in == bpao_pkg::OFF_PIN |=>
    rdata_out == $past(pin_sync))
    else $error("pin read wrong");
  chk_addr_over: assert property (ovr_en |=>
    port_pin_oe_out[3:0] == 4'hf && port_pin_out[3:0] == $past(ext_addr_hi_in))
    else $error("address override missing");
  chk_upper_free: assert property (!dir_reg[7] |=> port_pin_oe_out[7])
    else $error("upper pin overridden");
  chk_dir_kept: assert property (ovr_en && !wr_in |=> dir_reg == $past(dir_reg))
    else $error("direction changed by override");
  chk_enable_bit: assert property (1'b1 |=>
    ext_bus_enabled_out == !$past(mic_reg[bpao_pkg::MIC_BUS_DIS_BIT]))
    else $error("enable decode wrong");
  chk_reset_inputs: assert property (disable iff (1'b0) !reset_n_in |=>
    port_pin_oe_out == 8'h00 && dir_reg == bpao_pkg::DIR_RST && !ext_bus_enabled_out)
    else $error("reset left a pin driven");
  chk_dir_write: assert property (wr_in && addr_in == bpao_pkg::OFF_DIR |=>
    dir_reg == $past(wdata_in))
    else $error("direction write lost");
  chk_mic_write: assert property (wr_in && addr_in == bpao_pkg::OFF_MIC |=>
    mic_reg == $past(wdata_in))
    else $error("control write lost");
  chk_read_idle: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data held too long");
  chk_lat_read: assert property (rd_in && addr_in == bpao_pkg::OFF_LAT |=>
    rdata_out == $past(lat_reg))
    else $error("latch read shows pins");
  chk_dir_read: assert property (rd_in && addr_in == bpao_pkg::OFF_DIR |=>
    rdata_out == $past(dir_reg))
    else $error("direction read wrong");
  chk_ovr_ignores: assert property (ovr_en && dir_reg[3:0] != 4'h0 |=>
    port_pin_oe_out[3:0] == 4'hf)
    else $error("address pin left as input");
  chk_upper_latch: assert property (ovr_en && !dir_reg[4] |=>
    port_pin_oe_out[4] && port_pin_out[4] == $past(lat_reg[4]))
    else $error("upper pin lost latch");
  chk_upper_input: assert property (ovr_en && dir_reg[7] |=> !port_pin_oe_out[7])
    else $error("upper pin forced out");
  chk_low_release: assert property (!ovr_en && dir_reg[0] |=> !port_pin_oe_out[0])
    else $error("address pin still driven");
  chk_low_latch: assert property (!ovr_en && !dir_reg[2] |=>
    port_pin_out[2] == $past(lat_reg[2]))
    else $error("low pin not back on latch");
  chk_oe_follows: assert property (!ovr_en |=>
    port_pin_oe_out == ~$past(dir_reg))
    else $error("pin direction mixed");
  chk_out_follows: assert property (!ovr_en |=>
    port_pin_out == $past(lat_reg))
    else $error("pin drive not latch");
  chk_upper_out: assert property (ovr_en |=>
    port_pin_out[7:4] == $past(lat_reg[7:4]))
    else $error("upper pins overridden");
  chk_pin_sync: assert property (1'b1 |=> ##1
    pin_sync == $past(port_pin_in, 2))
    else $error("pin sampling delay wrong");

  cov_override: cover property (ovr_en ##1 !ovr_en);
  cov_output: cover property (!ovr_en && port_pin_oe_out[4]);
  cov_pin_read: cover property (rd_in && addr_in == bpao_pkg::OFF_PIN);
  cov_ovr_dir_wr: cover property (ovr_en && wr_in && addr_in == bpao_pkg::OFF_DIR);
  cov_lat_read: cover property (rd_in && addr_in == bpao_pkg::OFF_LAT);
endmodule

// [tb/bpao_board.sv]
`timescale 1ns/1ps
module bpao_board (
  input wire logic [7:0] drive_in,
  input wire logic [7:0] pin_out_in,
  input wire logic [7:0] pin_oe_in,
  output logic [7:0] level_out
);
  // Design wins wherever it drives; board level elsewhere
  assign level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & drive_in);
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
  logic clk_sys_in = 0, reset_n_in = 0, wr_in = 0, rd_in = 0, ov, ebus;
  logic [3:0] addr_in = 4'h0, ext_addr_hi_in = 4'h0;
  logic [7:0] wdata_in = 8'h00, brd = 8'h00, rdata_out, port_pin_in, port_pin_out;
  logic [7:0] port_pin_oe_out, r, dir, lat, eoe, exp_lvl;
  int errors = 0, n_tests = 0, cyc = 0;
  bpao_top bpao_top_i (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .ext_addr_hi_in(ext_addr_hi_in), .port_pin_in(port_pin_in), .port_pin_out(port_pin_out),
    .port_pin_oe_out(port_pin_oe_out), .ext_bus_enabled_out(ebus));
  bpao_board bpao_board_i (.drive_in(brd), .pin_out_in(port_pin_out),
    .pin_oe_in(port_pin_oe_out), .level_out(port_pin_in));
  // ****************************************
  // Bus tasks and checks
  // ****************************************
  initial forever #25 clk_sys_in = ~clk_sys_in;
  task close_out;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= v;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_sys_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask
  task check_reset;
    rd(4'h0, r);
    chk("dir", r, 8'hff);
    rd(4'h2, r);
    chk("lat", r, 8'h00);
    rd(4'h3, r);
    chk("memctl", r, 8'h80);
    chk("oe", port_pin_oe_out, 8'h00);
    chk("ebus", {7'h00, ebus}, 8'h00);
  endtask
  // Expected wire level: override, then latch, then board
  function automatic logic [7:0] lvl(input logic [7:0] dr, la, b, input logic o,
    input logic [3:0] ea);
    logic [7:0] oe;
    logic [7:0] d;
    oe = o ? (~dr | 8'h0f) : ~dr;
    d = o ? {la[7:4], ea} : la;
    return (oe & d) | (~oe & b);
  endfunction
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      close_out();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(45));
    repeat (16) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    check_reset();
    wr(4'h9, 8'h5a);
    rd(4'h9, r);
    chk("unmapped", r, 8'h00);
    for (int i = 0; i < 40; i++) begin
      // Corners first: all outputs, then all inputs
      dir = (i < 2) ? {8{i[0]}} : 8'($urandom);
      lat = (i < 2) ? ~dir : 8'($urandom);
      ov = (i >= 20);
      wr(4'h3, ov ? 8'h00 : 8'h80);
      brd <= 8'($urandom);
      ext_addr_hi_in <= 4'($urandom);
      wr(4'h0, dir);
      wr(i[0] ? 4'h1 : 4'h2, lat);
      repeat (4) @(posedge clk_sys_in);
      #1 eoe = ov ? (~dir | 8'h0f) : ~dir;
      exp_lvl = lvl(dir, lat, 8'h00, ov, ext_addr_hi_in);
      chk("oe", port_pin_oe_out, eoe);
      chk("drive", port_pin_out & eoe, exp_lvl);
      chk("ebus", {7'h00, ebus}, {7'h00, ov});
      rd(4'h0, r);
      chk("dir", r, dir);
      rd(4'h2, r);
      chk("lat", r, lat);
      rd(4'h1, r);
      chk("pins", r, lvl(dir, lat, brd, ov, ext_addr_hi_in));
      @(posedge clk_sys_in);
      #1 chk("rdata idle", rdata_out, 8'h00);
    end
    // Mid-run reset must drop every driver, override included
    @(posedge clk_sys_in);
    reset_n_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    reset_n_in <= 1'b1;
    check_reset();
    close_out();
  end
endmodule
